// [src/result_regs_pkg.sv]
// Constants shared by the conversion result register bank
package result_regs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CH0_HIGH_WORD = 8'h00;
  localparam logic [7:0] ADDR_CH0_LOW_WORD  = 8'h01;
  localparam logic [7:0] ADDR_CH1_HIGH_WORD = 8'h02;
  localparam logic [7:0] ADDR_CH1_LOW_WORD  = 8'h03;
  localparam logic [7:0] ADDR_CH2_HIGH_WORD = 8'h04;
  localparam logic [7:0] ADDR_CH2_LOW_WORD  = 8'h05;

  // ----------------------------------------------------------------
  // Field layout of a high word
  // ----------------------------------------------------------------
  localparam int          TIMEOUT_FLAG_BIT  = 13;
  localparam int          AMP_WARN_FLAG_BIT = 12;
  localparam int          RESULT_WIDTH      = 28;
  localparam int          WORD_WIDTH        = 16;
  localparam int          HIGH_DATA_WIDTH   = 12;
  localparam int          NUM_CHANNELS      = 3;
  localparam logic [1:0]  RESERVED_HIGH     = 2'h0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] WORD_RESET        = 16'h0000;
  localparam logic [27:0] RESULT_RESET      = 28'h000_0000;
  localparam logic [15:0] UNMAPPED_READ     = 16'h0000;

endpackage

// [src/result_channel.sv]
// One channel: latest result, sticky flags and the low-word snapshot
`timescale 1ns/100ps

module result_channel
  import result_regs_pkg::*;
#(
  parameter bit ENABLED  = 1'b1,
  parameter bit HIGH_RES = 1'b1
) (
  input  logic        i_clock,          // System clock
  input  logic        i_rst_n,          // Synchronous reset, active low
  input  logic        i_conv_done,      // Conversion finished, one cycle
  input  logic [27:0] i_conv_result,    // Result of that conversion
  input  logic        i_timeout,        // Watchdog timeout event, one cycle
  input  logic        i_amp_warn,       // Amplitude warning event, one cycle
  input  logic        i_high_read,      // Host reads the high word, one cycle
  output logic [15:0] o_high_word,      // Flags and result bits 27:16, or bits 11:0 without HIGH_RES
  output logic [15:0] o_low_word,       // Low half captured at high read
  output logic [27:0] o_value           // Latest result, only bits 11:0 kept without HIGH_RES
);

  logic [27:0] value_ff;
  logic [27:0] nxt_value;
  logic        timeout_ff;
  logic        nxt_timeout;
  logic        amp_warn_ff;
  logic        nxt_amp_warn;
  logic [15:0] low_snap_ff;
  logic [15:0] nxt_low_snap;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_value    = value_ff;
    nxt_low_snap = low_snap_ff;
    if (ENABLED && i_conv_done) begin
      nxt_value = HIGH_RES ? i_conv_result : {16'h0000, i_conv_result[11:0]};
    end
    // Event in the read cycle survives: set wins over clear
    nxt_timeout  = ENABLED && (i_timeout || (timeout_ff && !i_high_read));   // see R3 R7
    nxt_amp_warn = ENABLED && (i_amp_warn || (amp_warn_ff && !i_high_read)); // see R4 R8
    // Low half frozen with the high word so both come from one conversion
    if (ENABLED && HIGH_RES && i_high_read) begin
      nxt_low_snap = value_ff[15:0];                                          // see R11
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      value_ff    <= RESULT_RESET;
      timeout_ff  <= 1'b0;
      amp_warn_ff <= 1'b0;
      low_snap_ff <= WORD_RESET;
    end else begin
      value_ff    <= nxt_value;
      timeout_ff  <= nxt_timeout;
      amp_warn_ff <= nxt_amp_warn;
      low_snap_ff <= nxt_low_snap;
    end
  end

  // ----------------------------------------------------------------
  // Word views
  // ----------------------------------------------------------------
  assign o_high_word = {RESERVED_HIGH, timeout_ff, amp_warn_ff,
                        HIGH_RES ? value_ff[27:16] : value_ff[11:0]}; // see R2 R5 R9
  assign o_low_word  = low_snap_ff;                                   // see R1 R6 R9
  assign o_value     = value_ff;

endmodule

// [src/conversion_result_registers.sv]
// Read-only conversion result register bank with clear-on-read flags
`timescale 1ns/100ps

// Behaviour
// R1: Channel 0 low word at 0x01 returns result bits 15:0, resets zero.
// R2: Channel 1 high word: bits 15:14 zero, 13 timeout, 12 warning, 11:0 data.
// R3: Channel 1 timeout flag sets on timeout, clears when host reads it.
// R4: Channel 1 amplitude warning flag resets zero, clears when host reads it.
// R5: High word low twelve bits: result bits 11:0, or bits 27:16 on high-res.
// R6: Channel 1 low word at 0x03 returns result bits 15:0, resets zero.
// R7: Channel 2 timeout flag sets on timeout, clears on read (FOUR_CHAN set).
// R8: Channel 2 amplitude warning flag resets zero, clears on read.
// R9: Channel 2 result in high word 0x04 and low word 0x05.
// R10: Host reads a channel's high word before its low word; the testbench conversion loop reads the low word first.
// R11: Reading a high word captures the matching low word simultaneously.
module conversion_result_registers
  import result_regs_pkg::*;
#(
  parameter bit HIGH_RES  = 1'b1,
  parameter bit FOUR_CHAN = 1'b1
) (
  input  logic             i_clock,        // 125 MHz system clock
  input  logic             i_rst_n,        // Synchronous reset, active low
  input  logic [2:0]       i_conv_done,    // Per-channel conversion done pulse
  input  logic [2:0][27:0] i_conv_result,  // Per-channel conversion result
  input  logic [2:0]       i_timeout,      // Per-channel watchdog timeout pulse
  input  logic [2:0]       i_amp_warn,     // Per-channel amplitude warning pulse
  input  logic             i_rd_strobe,    // Serial interface read request
  input  logic [7:0]       i_rd_addr,      // Register address of that read
  output logic [15:0]      o_rd_data,      // Read data, valid with o_rd_valid
  output logic             o_rd_valid      // Read data valid, one cycle
);

  logic [2:0]       high_read;
  logic [2:0][15:0] high_word;
  logic [2:0][15:0] low_word;
  logic [2:0][27:0] chan_value;
  logic [15:0]      rd_data_ff;
  logic [15:0]      nxt_rd_data;
  logic             rd_valid_ff;
  logic             nxt_rd_valid;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  assign high_read[0] = i_rd_strobe && (i_rd_addr == ADDR_CH0_HIGH_WORD);
  assign high_read[1] = i_rd_strobe && (i_rd_addr == ADDR_CH1_HIGH_WORD);
  assign high_read[2] = i_rd_strobe && (i_rd_addr == ADDR_CH2_HIGH_WORD);

  for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
    result_channel #(
      .ENABLED  ((ch < 2) || FOUR_CHAN),
      .HIGH_RES (HIGH_RES)
    ) u_chan (
      .i_clock       (i_clock),
      .i_rst_n       (i_rst_n),
      .i_conv_done   (i_conv_done[ch]),
      .i_conv_result (i_conv_result[ch]),
      .i_timeout     (i_timeout[ch]),
      .i_amp_warn    (i_amp_warn[ch]),
      .i_high_read   (high_read[ch]),
      .o_high_word   (high_word[ch]),
      .o_low_word    (low_word[ch]),
      .o_value       (chan_value[ch])
    );
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rd_valid = i_rd_strobe;
    nxt_rd_data  = rd_data_ff;
    if (i_rd_strobe) begin
      case (i_rd_addr)
        ADDR_CH0_HIGH_WORD: nxt_rd_data = high_word[0];
        ADDR_CH0_LOW_WORD:  nxt_rd_data = HIGH_RES ? low_word[0] : UNMAPPED_READ; // see R1
        ADDR_CH1_HIGH_WORD: nxt_rd_data = high_word[1];                           // see R2
        ADDR_CH1_LOW_WORD:  nxt_rd_data = HIGH_RES ? low_word[1] : UNMAPPED_READ; // see R6
        ADDR_CH2_HIGH_WORD: nxt_rd_data = FOUR_CHAN ? high_word[2] : UNMAPPED_READ;
        ADDR_CH2_LOW_WORD:  nxt_rd_data = (FOUR_CHAN && HIGH_RES) ? low_word[2]
                                                                  : UNMAPPED_READ; // see R9
        default:            nxt_rd_data = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rd_data_ff  <= WORD_RESET;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_data_ff  <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  assign o_rd_data  = rd_data_ff;
  assign o_rd_valid = rd_valid_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] last_addr_ff;
  logic [7:0] nxt_last_addr;

  always_comb begin
    nxt_last_addr = last_addr_ff;
    if (i_rd_strobe) begin
      nxt_last_addr = i_rd_addr;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      last_addr_ff <= ADDR_CH0_HIGH_WORD;
    end else begin
      last_addr_ff <= nxt_last_addr;
    end
  end

  a_ch0_low_read: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R1
    i_rd_strobe && (i_rd_addr == ADDR_CH0_LOW_WORD)
    |=> o_rd_valid && (o_rd_data == (HIGH_RES ? $past(low_word[0]) : 16'h0000)))
    else $error("channel 0 low word read wrong");

  a_ch1_high_layout: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R2
    o_rd_valid && (last_addr_ff == ADDR_CH1_HIGH_WORD) |-> (o_rd_data[15:14] == 2'h0))
    else $error("channel 1 reserved bits not zero");

  a_ch1_timeout_set: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R3
    i_timeout[1] |=> high_word[1][TIMEOUT_FLAG_BIT] ##1
    (o_rd_data[TIMEOUT_FLAG_BIT] || !$past(high_read[1])))
    else $error("channel 1 timeout flag not set");

  a_ch1_timeout_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R3
    high_read[1] && !i_timeout[1] |=> !high_word[1][TIMEOUT_FLAG_BIT])
    else $error("channel 1 timeout flag not cleared by read");

  a_ch1_warn_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R4
    high_read[1] && !i_amp_warn[1] && high_word[1][AMP_WARN_FLAG_BIT]
    |=> o_rd_data[AMP_WARN_FLAG_BIT] && !high_word[1][AMP_WARN_FLAG_BIT])
    else $error("channel 1 warning flag read or clear wrong");

  a_ch1_result_bits: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R5
    i_conv_done[1] |=> (high_word[1][11:0] == (HIGH_RES ? $past(i_conv_result[1][27:16])
                                                        : $past(i_conv_result[1][11:0]))))
    else $error("channel 1 high word data wrong");

  a_ch1_low_read: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R6
    i_rd_strobe && (i_rd_addr == ADDR_CH1_LOW_WORD)
    |=> (o_rd_data == (HIGH_RES ? $past(low_word[1]) : 16'h0000)))
    else $error("channel 1 low word read wrong");

  a_ch2_timeout_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R7
    i_timeout[2] |=> (high_word[2][TIMEOUT_FLAG_BIT] == FOUR_CHAN))
    else $error("channel 2 timeout flag wrong");

  a_ch2_warn_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R8
    high_read[2] && !i_amp_warn[2] |=> !high_word[2][AMP_WARN_FLAG_BIT])
    else $error("channel 2 warning flag not cleared by read");

  a_ch2_high_read: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R9
    high_read[2] |=> (o_rd_data == (FOUR_CHAN ? $past(high_word[2]) : 16'h0000)))
    else $error("channel 2 high word read wrong");

  a_low_snapshot: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R11
    high_read[1] |=> (low_word[1] == (HIGH_RES ? $past(chan_value[1][15:0]) : 16'h0000)))
    else $error("channel 1 low word not captured with high word");

  a_unmapped_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_rd_strobe && (i_rd_addr > ADDR_CH2_LOW_WORD) |=> (o_rd_data == 16'h0000))
    else $error("unmapped read not zero");

  a_rd_valid_pulse: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_rd_strobe |=> o_rd_valid)
    else $error("read not answered one cycle after strobe");

  a_rd_valid_idle: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !i_rd_strobe |=> !o_rd_valid)
    else $error("read valid without a strobe");

  a_rd_data_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !i_rd_strobe |=> $stable(o_rd_data))
    else $error("read data moved between reads");

  a_ch0_snapshot: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R1 R11
    high_read[0] |=> (low_word[0] == (HIGH_RES ? $past(chan_value[0][15:0]) : 16'h0000)))
    else $error("channel 0 low word not captured with high word");

  a_ch2_snapshot: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R9 R11
    high_read[2] |=> (low_word[2] == ((FOUR_CHAN && HIGH_RES) ? $past(chan_value[2][15:0])
                                                               : 16'h0000)))
    else $error("channel 2 low word not captured with high word");

  a_ch1_warn_set: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R4
    i_amp_warn[1] |=> high_word[1][AMP_WARN_FLAG_BIT])
    else $error("channel 1 warning flag not set");

  a_ch2_warn_set: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R8
    i_amp_warn[2] |=> (high_word[2][AMP_WARN_FLAG_BIT] == FOUR_CHAN))
    else $error("channel 2 warning flag not set");

  a_ch2_timeout_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R7
    high_read[2] && !i_timeout[2] |=> !high_word[2][TIMEOUT_FLAG_BIT])
    else $error("channel 2 timeout flag not cleared by read");

  a_ch2_result_bits: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R9
    i_conv_done[2] |=> (high_word[2][11:0] == (!FOUR_CHAN ? 12'h000
                        : (HIGH_RES ? $past(i_conv_result[2][27:16])
                                    : $past(i_conv_result[2][11:0])))))
    else $error("channel 2 high word data wrong");

  a_low_read_quiet: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R6
    i_rd_strobe && (i_rd_addr == ADDR_CH1_LOW_WORD) |=> $stable(low_word[1]))
    else $error("channel 1 low word read had a side effect");

  a_ch1_high_read: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see R2 R3
    high_read[1] |=> (o_rd_data == $past(high_word[1])))
    else $error("channel 1 high word read wrong");

  a_ch0_high_read: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    high_read[0] |=> (o_rd_data == $past(high_word[0])))
    else $error("channel 0 high word read wrong");

  c_high_then_low: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    high_read[1] ##[1:8] (i_rd_strobe && (i_rd_addr == ADDR_CH1_LOW_WORD)));

  c_timeout_read: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    i_timeout[2] ##[1:8] high_read[2]);

  c_set_and_read: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    i_amp_warn[1] && high_read[1]);

  c_ch0_pair: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    high_read[0] ##1 (i_rd_strobe && (i_rd_addr == ADDR_CH0_LOW_WORD)));

endmodule

// [test/host_model.sv]
// Host-side model that issues register reads and collects the answers
`timescale 1ns/100ps

module host_model (
  input  wire logic        i_clock,     // System clock
  input  wire logic        i_rd_valid,  // Answer valid
  input  wire logic [15:0] i_rd_data,   // Answer data
  output logic             o_rd_strobe, // Read request
  output logic [7:0]       o_rd_addr    // Read address
);
  initial begin
    o_rd_strobe = 1'b0;
    o_rd_addr   = 8'hff;
  end

  // One request cycle, then a bounded wait; ok means answered one cycle later
  task automatic rd(input logic [7:0] addr, output logic [15:0] data, output bit ok);
    int n;
    n = 0;
    @(negedge i_clock);
    o_rd_strobe = 1'b1;
    o_rd_addr   = addr;
    @(negedge i_clock);
    o_rd_strobe = 1'b0;
    o_rd_addr   = ~addr;
    while (i_rd_valid !== 1'b1 && n < 4) begin
      @(negedge i_clock);
      n++;
    end
    data = i_rd_data;
    ok   = (n == 0);
  endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the conversion result register bank
`timescale 1ns/100ps

module testbench;
  import result_regs_pkg::*;
  logic             clock;
  logic             rst_n;
  logic [2:0]       done;
  logic [2:0][27:0] cres;
  logic [2:0]       tmo;
  logic [2:0]       amp;
  logic             strobe;
  logic [7:0]       addr;
  logic [15:0]      rdata;
  logic             rvalid;
  logic [15:0]      fdata;
  logic             fvalid;
  int               seed = 32'hb8c4c7d7;
  int               err_total = 0;
  int               checked = 0;
  int               res[3];
  int               wd[3];
  int               aw[3];
  int               snap[3];
  int               c;

  conversion_result_registers dut_u (.i_clock(clock), .i_rst_n(rst_n), .i_conv_done(done),
    .i_conv_result(cres), .i_timeout(tmo), .i_amp_warn(amp), .i_rd_strobe(strobe),
    .i_rd_addr(addr), .o_rd_data(rdata), .o_rd_valid(rvalid));
  host_model host_u (.i_clock(clock), .i_rd_valid(rvalid), .i_rd_data(rdata),
    .o_rd_strobe(strobe), .o_rd_addr(addr));
  // Fast two-channel variant on the same stimulus
  conversion_result_registers #(.HIGH_RES(1'b0), .FOUR_CHAN(1'b0)) fast_u (.i_clock(clock),
    .i_rst_n(rst_n), .i_conv_done(done), .i_conv_result(cres), .i_timeout(tmo),
    .i_amp_warn(amp), .i_rd_strobe(strobe), .i_rd_addr(addr), .o_rd_data(fdata),
    .o_rd_valid(fvalid));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ------------------------------------------------------------
  // Reference model and checks
  // ------------------------------------------------------------
  function automatic logic [15:0] expect_rd(int a);
    if (a < 6 && a % 2 == 0)
      return {2'b00, 1'(wd[a/2]), 1'(aw[a/2]), 12'(res[a/2] >>> 16)};
    if (a < 6)
      return 16'(snap[a/2]);
    return 16'h0000;
  endfunction

  // Fast variant: 12-bit result in the high word, no low words, no channel 2
  function automatic logic [15:0] expect_fast(int a);
    if (a < 4 && a % 2 == 0)
      return {2'b00, 1'(wd[a/2]), 1'(aw[a/2]), 12'(res[a/2])};
    return 16'h0000;
  endfunction

  task automatic cmp_word(input int a, input logic [15:0] e, input logic [15:0] g,
                          input bit ok);
    checked++;
    if (g !== e || !ok) begin
      err_total++;
      $display("[FAIL] t=%0t addr=%h exp=%h got=%h", $time, a, e, g);
    end
  endtask

  task automatic rd_chk(input int a);
    logic [15:0] d;
    logic [15:0] e;
    logic [15:0] f;
    bit          ok;
    e = expect_rd(a);
    f = expect_fast(a);
    host_u.rd(8'(a), d, ok);
    cmp_word(a, e, d, ok);
    cmp_word(a, f, fdata, ok && fvalid === 1'b1);
    if (a < 6 && a % 2 == 0) begin
      snap[a/2] = res[a/2];
      wd[a/2]   = 0;
      aw[a/2]   = 0;
    end
  endtask

  task automatic fire(input int ch);
    logic [27:0] r;
    logic        t;
    logic        w;
    r = 28'($random(seed));
    t = 1'($random(seed));
    w = 1'($random(seed));
    @(negedge clock);
    done[ch] = 1'b1;
    cres[ch] = r;
    tmo[ch]  = t;
    amp[ch]  = w;
    @(negedge clock);
    done = 3'h0;
    tmo  = 3'h0;
    amp  = 3'h0;
    res[ch] = int'(r);
    if (t) wd[ch] = 1;
    if (w) aw[ch] = 1;
  endtask

  // Flag events placed in the same cycle as a high-word read strobe
  task automatic pulse(input int ch);
    @(negedge clock);
    tmo[ch] = 1'b1;
    amp[ch] = 1'b1;
    @(negedge clock);
    tmo = 3'h0;
    amp = 3'h0;
  endtask

  task automatic final_report();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    #(8 * 5000);
    err_total++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    done  = 3'h0;
    cres  = '0;
    tmo   = 3'h0;
    amp   = 3'h0;
    for (int i = 0; i < 3; i++) begin
      res[i]  = 0;
      wd[i]   = 0;
      aw[i]   = 0;
      snap[i] = 0;
    end
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    for (int a = 0; a < 8; a++) rd_chk(a);
    rd_chk(255);
    $display("reset values test done");
    repeat (30) begin
      c = {$random(seed)} % 3;
      fire(c);
      rd_chk(2 * c + 1);
      rd_chk(2 * c);
      if ($random(seed) & 1) fire(c);
      rd_chk(2 * c + 1);
      rd_chk(2 * c);
    end
    $display("conversion and flag test done");
    for (int ch = 0; ch < 3; ch++) begin
      fork
        rd_chk(2 * ch);
        pulse(ch);
      join
      wd[ch] = 1;
      aw[ch] = 1;
      rd_chk(2 * ch);
      rd_chk(2 * ch);
    end
    $display("set over clear test done");
    final_report();
  end
endmodule
